//--- rtl/nfh_host.sv
/*
  host side pin sequencer for an 8-bit multiplexed nand flash.
  user issues one bus cycle per request (command, address, data in/out,
  wait for ready, deselect). assumes an external pull-up on ready/busy.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nfh_map.svh"

// Function
// - command byte on write strobe with cmd_latch
// - address byte on write strobe with addr_latch
// - data byte when both latch selects low
// - busy is open drain, pulled up outside the host
// - read/program take column, row lo, row hi
// - erase uses setup, two rows, confirm
module nfh_host
  import nfh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [7:0] req_data,
  input wire logic req_spare_off,
  input wire logic req_lockout_n,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic chip_sel_n,
  output logic cmd_latch,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic spare_area_disable,
  output logic prog_lockout_n,
  output logic [7:0] shared_bus_pins_o,
  output logic shared_bus_pins_oe,
  input wire logic [7:0] shared_bus_pins_i,
  input wire logic ready_busy_n
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [7:0] bus_s1_q, bus_s2_q;
  logic rb_s1_q, rb_s2_q;
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      bus_s1_q <= 8'h00;
      bus_s2_q <= 8'h00;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end
    else
    begin
      bus_s1_q <= shared_bus_pins_i;
      bus_s2_q <= bus_s1_q;
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ****************************************
  // bus cycle sequencer
  // ****************************************
  nfh_state_e st_q, st_d;
  nfh_op_e op_q, op_d;
  logic [3:0] cnt_q, cnt_d;
  logic ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d;
  logic [7:0] dout_q, dout_d, rdat_q, rdat_d;
  logic oe_q, oe_d, rdy_q, rdy_d, rv_q, rv_d, sp_q, sp_d, lk_q, lk_d;

  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    cnt_d = cnt_q;
    ce_n_d = ce_n_q;
    cle_d = cle_q;
    ale_d = ale_q;
    we_n_d = we_n_q;
    re_n_d = re_n_q;
    dout_d = dout_q;
    oe_d = oe_q;
    rdat_d = rdat_q;
    rdy_d = rdy_q;
    rv_d = 1'b0;
    sp_d = sp_q;
    lk_d = lk_q;
    unique case (st_q)
      NFH_IDLE:
      begin
        if (req_valid && rdy_q)
        begin
          rdy_d = 1'b0;
          op_d = nfh_op_e'(req_op);
          sp_d = req_spare_off;
          lk_d = req_lockout_n;
          cnt_d = 4'(`NFH_WP_CYC);
          unique case (nfh_op_e'(req_op))
            NFH_OP_CMD, NFH_OP_ADDR, NFH_OP_WDATA:
            begin
              // latch selects fix the meaning of the rising write strobe
              ce_n_d = 1'b0;
              cle_d = (nfh_op_e'(req_op) == NFH_OP_CMD);
              ale_d = (nfh_op_e'(req_op) == NFH_OP_ADDR);
              dout_d = req_data;
              oe_d = 1'b1;
              we_n_d = 1'b0;
              st_d = NFH_LOW;
            end
            NFH_OP_RDATA:
            begin
              ce_n_d = 1'b0;
              cle_d = 1'b0;
              ale_d = 1'b0;
              oe_d = 1'b0;
              re_n_d = 1'b0;
              cnt_d = 4'(`NFH_RP_CYC);
              st_d = NFH_LOW;
            end
            NFH_OP_WAIT:
            begin
              // busy goes low only after a short delay past the strobe
              cnt_d = 4'(`NFH_WB_CYC);
              st_d = NFH_BUSY;
            end
            default:
            begin
              // deselect abandons a read; program/erase run on regardless
              ce_n_d = 1'b1;
              cle_d = 1'b0;
              ale_d = 1'b0;
              oe_d = 1'b0;
              rv_d = 1'b1;
              rdy_d = 1'b1;
            end
          endcase
        end
      end
      NFH_LOW:
      begin
        if (cnt_q > 4'h1)
          cnt_d = cnt_q - 4'h1;
        else
        begin
          we_n_d = 1'b1;
          re_n_d = 1'b1;
          cnt_d = 4'(`NFH_WH_CYC);
          st_d = NFH_HIGH;
        end
      end
      NFH_HIGH:
      begin
        if (cnt_q > 4'h1)
          cnt_d = cnt_q - 4'h1;
        else
        begin
          // hold data one cycle past the rising strobe, then release
          oe_d = 1'b0;
          // synchroniser lag: the read byte reaches stage two only now
          if (op_q == NFH_OP_RDATA)
            rdat_d = bus_s2_q;
          rv_d = 1'b1;
          rdy_d = 1'b1;
          st_d = NFH_IDLE;
        end
      end
      NFH_BUSY:
      begin
        if (cnt_q != 4'h0)
          cnt_d = cnt_q - 4'h1;
        else if (rb_s2_q)
        begin
          rv_d = 1'b1;
          rdy_d = 1'b1;
          st_d = NFH_IDLE;
        end
      end
      default:
      begin
        st_d = NFH_IDLE;
        rdy_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_q <= NFH_IDLE;
      op_q <= NFH_OP_CMD;
      cnt_q <= 4'h0;
      ce_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      dout_q <= 8'h00;
      oe_q <= 1'b0;
      rdat_q <= 8'h00;
      rdy_q <= 1'b1;
      rv_q <= 1'b0;
      sp_q <= 1'b0;
      lk_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      ce_n_q <= ce_n_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      rdat_q <= rdat_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      sp_q <= sp_d;
      lk_q <= lk_d;
    end
  end

  assign req_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_data = rdat_q;
  assign chip_sel_n = ce_n_q;
  assign cmd_latch = cle_q;
  assign addr_latch = ale_q;
  assign write_strobe_n = we_n_q;
  assign read_strobe_n = re_n_q;
  assign spare_area_disable = sp_q;
  assign prog_lockout_n = lk_q;
  assign shared_bus_pins_o = dout_q;
  assign shared_bus_pins_oe = oe_q;
endmodule
`default_nettype wire

//--- include/nfh_map.svh
/*
  timing counts and command codes for the nand pin host controller.
  assumes a 25 MHz ref_clk; counts derive from times in ns.
*/
`ifndef NFH_MAP_SVH
`define NFH_MAP_SVH
`define NFH_CLK_NS 40
`define NFH_T_WP_NS 25
`define NFH_T_WH_NS 15
`define NFH_T_RP_NS 30
`define NFH_T_REA_NS 35
`define NFH_T_REH_NS 15
`define NFH_T_WB_NS 100
`define NFH_WP_CYC ((`NFH_T_WP_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_WH_CYC ((`NFH_T_WH_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_RP_CYC ((`NFH_T_REA_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS + 1)
`define NFH_WB_CYC ((`NFH_T_WB_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_CMD_READ_LO 8'h00
`define NFH_CMD_PROG_SETUP 8'h80
`define NFH_CMD_PROG_GO 8'h10
`define NFH_CMD_ERASE_SETUP 8'h60
`define NFH_CMD_ERASE_GO 8'hD0
`endif

//--- include/nfh_pkg.sv
/*
  types for the nand pin host controller.
  assumes nfh_map.svh is on the include path.
*/
`default_nettype none
package nfh_pkg;
  typedef enum logic [2:0]
  {
    NFH_OP_CMD = 3'h0,
    NFH_OP_ADDR = 3'h1,
    NFH_OP_WDATA = 3'h2,
    NFH_OP_RDATA = 3'h3,
    NFH_OP_WAIT = 3'h4,
    NFH_OP_DESEL = 3'h5
  } nfh_op_e;
  typedef enum logic [3:0]
  {
    NFH_IDLE = 4'b0001,
    NFH_LOW = 4'b0010,
    NFH_HIGH = 4'b0100,
    NFH_BUSY = 4'b1000
  } nfh_state_e;
endpackage
`default_nettype wire

//--- verif/nfh_host_monitor.sv
/* pin checker for nfh_host
   sees only the host ports */
`timescale 1ns/1ps
`default_nettype none
module nfh_host_monitor (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic chip_sel_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic shared_bus_pins_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wr_sel_a:
    assert property ($fell(write_strobe_n) |-> shared_bus_pins_oe && !chip_sel_n) else $error("wsel");
  wr_pulse_a:
    assert property ($fell(write_strobe_n) |=> $rose(write_strobe_n)) else $error("wpulse");
  wr_done_a:
    assert property ($rose(write_strobe_n) |=> rsp_valid && req_ready) else $error("wdone");
  rd_pulse_a:
    assert property ($fell(read_strobe_n) |=> !read_strobe_n ##1 read_strobe_n) else $error("rp");
  strobe_excl_a:
    assert property (write_strobe_n || read_strobe_n) else $error("strobes");
  rd_float_a:
    assert property (!read_strobe_n |-> !shared_bus_pins_oe) else $error("rfloat");
  desel_float_a:
    assert property (chip_sel_n |-> !shared_bus_pins_oe) else $error("dfloat");
  latch_hold_a:
    assert property ($fell(write_strobe_n) |=> $stable(cmd_latch) && $stable(addr_latch))
      else $error("lhold");
  latch_excl_a:
    assert property (!(cmd_latch && addr_latch)) else $error("latch");
endmodule
bind nfh_host nfh_host_monitor u_mon (.ref_clk, .rstn, .req_ready, .rsp_valid, .chip_sel_n,
  .cmd_latch, .addr_latch, .write_strobe_n, .read_strobe_n, .shared_bus_pins_oe);
`default_nettype wire

//--- verif/nfh_flash_model.sv
/* behavioural nand device on the host pins
   bench resolves the bus and pulls ready/busy up */
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model (
  input wire logic chip_sel_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic prog_lockout_n,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic busy_q
);
  logic [7:0] cmd_q = 8'h00, addr_q = 8'h00, wr_q = 8'h00, rd_q = 8'h00;
  logic [7:0] mem [4];
  logic [1:0] col_q = 2'h0;
  logic drive_q = 1'b0;
  initial busy_q = 1'b0;
  // released bus shows the inverse, never a stale byte
  assign bus_out = drive_q ? rd_q : ~rd_q;
  always @(posedge write_strobe_n)
    if (!chip_sel_n)
    begin
      if (cmd_latch)
        cmd_q = bus_in;
      else if (addr_latch)
      begin
        addr_q = bus_in;
        col_q = 2'h0;
      end
      else
      begin
        wr_q = bus_in;
        mem[col_q] = bus_in;
        col_q++;
      end
      if (cmd_latch && prog_lockout_n && (bus_in == 8'h10 || bus_in == 8'hD0))
      begin
        // off the clock grid so the host never races the busy edge
        #90 busy_q = 1'b1;
        #400 busy_q = 1'b0;
      end
    end
  always @(negedge read_strobe_n)
    if (!chip_sel_n)
    begin
      #35 rd_q = mem[col_q];
      drive_q = 1'b1;
      col_q++;
    end
  always @(posedge read_strobe_n or posedge chip_sel_n)
    drive_q = 1'b0;
endmodule
`default_nettype wire

//--- verif/tb.sv
/* self-checking bench for nfh_host
   device model on the pins, pull-up on ready/busy */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_spare_off = 1'b0;
  logic req_lockout_n = 1'b1, busy_low;
  logic [2:0] req_op = 3'h0;
  logic [7:0] req_data = 8'h00, rsp_data, shared_bus_pins_o, dev_bus;
  logic req_ready, rsp_valid, chip_sel_n, cmd_latch, addr_latch, write_strobe_n;
  logic read_strobe_n, spare_area_disable, prog_lockout_n, shared_bus_pins_oe;
  wire logic [7:0] shared_bus_pins_i = shared_bus_pins_oe ? shared_bus_pins_o : dev_bus;
  wire logic ready_busy_n = busy_low ? 1'b0 : 1'b1;
  int num_errors = 0, check_count = 0, cycles = 0;
  // {op, byte}: byte is also what the row should give back
  logic [11:0] rows [19] = '{12'h080, 12'h100, 12'h112, 12'h134, 12'h2A5, 12'h23C, 12'h010,
    12'h400, 12'h000, 12'h100, 12'h112, 12'h134, 12'h3A5, 12'h33C, 12'h060, 12'h112,
    12'h134, 12'h0D0, 12'h400};
  always #20 ref_clk = ~ref_clk;
  nfh_host DUT (.ref_clk, .rstn, .req_valid, .req_op, .req_data, .req_spare_off,
    .req_lockout_n, .req_ready, .rsp_valid, .rsp_data, .chip_sel_n, .cmd_latch, .addr_latch,
    .write_strobe_n, .read_strobe_n, .spare_area_disable, .prog_lockout_n,
    .shared_bus_pins_o, .shared_bus_pins_oe, .shared_bus_pins_i, .ready_busy_n);
  nfh_flash_model u_dev (.chip_sel_n, .cmd_latch, .addr_latch, .write_strobe_n,
    .read_strobe_n, .prog_lockout_n, .bus_in(shared_bus_pins_i), .bus_out(dev_bus),
    .busy_q(busy_low));
  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string nm);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic req(input logic [2:0] op, input logic [7:0] d);
    req_valid = 1'b1;
    req_op = op;
    req_data = d;
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    while (rsp_valid !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  // hang guard: whole run needs well under 1000 cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  //****************
  // main sequence
  //****************
  initial
  begin
    repeat (5) @(posedge ref_clk);
    #1 rstn = 1'b1;
    foreach (rows[i])
    begin
      req(rows[i][10:8], rows[i][7:0]);
      case (rows[i][11:8])
        4'h0: chk(u_dev.cmd_q, rows[i][7:0], "cmd");
        4'h1: chk(u_dev.addr_q, rows[i][7:0], "addr");
        4'h2: chk(u_dev.wr_q, rows[i][7:0], "wdata");
        4'h3: chk(rsp_data, rows[i][7:0], "rdata");
        default: chk(ready_busy_n, 1'b1, "ready");
      endcase
    end
    req_lockout_n = 1'b0;
    req_spare_off = 1'b1;
    req(3'h0, 8'h10);
    repeat (4) @(posedge ref_clk);
    #1 chk(ready_busy_n, 1'b1, "locked");
    chk(prog_lockout_n, 1'b0, "lockpin");
    chk(spare_area_disable, 1'b1, "spare");
    req_lockout_n = 1'b1;
    req(3'h0, 8'h10);
    repeat (3) @(posedge ref_clk);
    #1 chk(ready_busy_n, 1'b0, "busy");
    req(3'h5, 8'h00);
    chk(chip_sel_n, 1'b1, "desel");
    chk(ready_busy_n, 1'b0, "busy_desel");
    req(3'h4, 8'h00);
    chk(ready_busy_n, 1'b1, "done");
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk(chip_sel_n, 1'b1, "cs_rst");
    chk(prog_lockout_n, 1'b0, "lock_rst");
    chk(req_ready, 1'b1, "rdy_rst");
    chk({write_strobe_n, read_strobe_n, cmd_latch, addr_latch}, 8'h0C, "pins_rst");
    chk(shared_bus_pins_oe, 1'b0, "oe_rst");
    chk(rsp_valid, 1'b0, "rv_rst");
    rstn = 1'b1;
    req(3'h0, 8'hFF);
    chk(u_dev.cmd_q, 8'hFF, "cmd_after_rst");
    chk(prog_lockout_n, 1'b1, "lock_after_rst");
    tally_and_finish();
  end
endmodule
`default_nettype wire
